// *** aiq_pkg.sv ***
package aiq_pkg;
  // Converter, store and event sizes
  localparam int AIQ_DW = 16;
  localparam int AIQ_NCH = 8;
  localparam int AIQ_DEPTH = 1024;
  localparam int AIQ_NEV = 6;
  // Register byte offsets
  localparam logic [5:0] AIQ_OFS_CTRL = 6'h00;
  localparam logic [5:0] AIQ_OFS_CFG = 6'h04;
  localparam logic [5:0] AIQ_OFS_CHEN = 6'h08;
  localparam logic [5:0] AIQ_OFS_PERIOD = 6'h0C;
  localparam logic [5:0] AIQ_OFS_SLVL = 6'h10;
  localparam logic [5:0] AIQ_OFS_PLVL = 6'h14;
  localparam logic [5:0] AIQ_OFS_STOPCNT = 6'h18;
  localparam logic [5:0] AIQ_OFS_THR = 6'h1C;
  localparam logic [5:0] AIQ_OFS_STATUS = 6'h20;
  localparam logic [5:0] AIQ_OFS_EVENT = 6'h24;
  localparam logic [5:0] AIQ_OFS_COUNT = 6'h28;
  localparam logic [5:0] AIQ_OFS_DATA = 6'h2C;
  // Command bits of the control register
  localparam int AIQ_CTRL_START = 0;
  localparam int AIQ_CTRL_ABORT = 1;
  localparam int AIQ_CTRL_MEMRST = 2;
  localparam int AIQ_CTRL_STSRST = 3;
  // Configuration fields
  localparam int AIQ_CFG_RING = 0;
  localparam int AIQ_CFG_EXTCLK = 1;
  localparam int AIQ_CFG_SRC_LSB = 2;
  localparam int AIQ_CFG_STP_LSB = 4;
  localparam int AIQ_CFG_SDIR_LSB = 6;
  localparam int AIQ_CFG_PDIR_LSB = 8;
  localparam int AIQ_CFG_SEDGE = 10;
  localparam int AIQ_CFG_PEDGE = 11;
  localparam int AIQ_CFG_SCH_LSB = 12;
  localparam int AIQ_CFG_PCH_LSB = 16;
  // Start and stop source codes, direction bits
  localparam logic [1:0] AIQ_SRC_SW = 2'h0;
  localparam logic [1:0] AIQ_SRC_CMP = 2'h1;
  localparam logic [1:0] AIQ_SRC_EXT = 2'h2;
  localparam logic [1:0] AIQ_STP_COUNT = 2'h0;
  localparam logic [1:0] AIQ_STP_CMP = 2'h1;
  localparam logic [1:0] AIQ_STP_EXT = 2'h2;
  localparam logic [1:0] AIQ_STP_ABORT = 2'h3;
  localparam int AIQ_DIR_RISE = 0;
  localparam int AIQ_DIR_FALL = 1;
  // Status and event bit positions
  localparam int AIQ_ST_BUSY = 0;
  localparam int AIQ_ST_WAIT = 1;
  localparam int AIQ_ST_CNTR = 2;
  localparam int AIQ_ST_OVF = 3;
  localparam int AIQ_ST_CLKE = 4;
  localparam int AIQ_ST_CNVE = 5;
  localparam int AIQ_EV_START = 0;
  localparam int AIQ_EV_STOP = 1;
  localparam int AIQ_EV_CNT = 2;
  localparam int AIQ_EV_OVF = 3;
  localparam int AIQ_EV_CLKE = 4;
  localparam int AIQ_EV_CNVE = 5;
  // Reset values
  localparam logic [31:0] AIQ_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] AIQ_CHEN_RST = 32'h0000_0001;
  localparam logic [31:0] AIQ_PERIOD_RST = 32'h0000_03E8;
  localparam logic [31:0] AIQ_LVL_RST = 32'h0000_8000;
  localparam logic [31:0] AIQ_STOPCNT_RST = 32'h0000_0064;
  localparam logic [31:0] AIQ_THR_RST = 32'h0000_0000;
  // Sequencer states
  typedef enum logic [1:0] {AIQ_IDLE, AIQ_ARM, AIQ_RUN} aiq_state_type;
  typedef enum logic [1:0] {
    AIQ_PH_IDLE, AIQ_PH_CONV, AIQ_PH_EVAL, AIQ_PH_COMMIT
  } aiq_phase_type;

  // Level crossing between two successive codes
  function automatic logic aiq_cross(input logic [15:0] prev,
      input logic [15:0] cur, input logic [15:0] lvl,
      input logic [1:0] dir);
    logic up;
    logic dn;
    up = (prev < lvl) && (cur >= lvl);
    dn = (prev >= lvl) && (cur < lvl);
    return (dir[AIQ_DIR_RISE] & up) | (dir[AIQ_DIR_FALL] & dn);
  endfunction
endpackage

// *** aiq_sequencer.sv ***
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
// Operation
// - results are unsigned 16-bit codes
// - scan enabled channels upward from channel 0
// - FIFO hands out oldest sample first
// - ring overwrites oldest slot when full
// - pacing from internal timer or external clock
// - external clock gives one sample per rising edge
// - start and stop sources chosen independently
// - software start stores from start command
// - comparison start stores once crossing seen
// - crossing direction rising, falling or both
// - external start waits for selected trigger edge
// - count stop after programmed sampling instants
// - comparison stop keeps satisfying sample, then stops
// - external stop armed after programmed count
// - software abort ends sampling
// - any error halts sampling
// - start-met event, never for software start
// - stopped event when activity ends
// - count-reached event at programmed threshold
// - overflow event on write into full store
// - clock-error and conversion-error events
// - FIFO overflow stops, ring keeps converting
// - FIFO count status clears, ring holds
// - code 32768 is zero volts, linear
module aiq_sequencer #(
  parameter int NCH = aiq_pkg::AIQ_NCH,
  parameter int DEPTH = aiq_pkg::AIQ_DEPTH
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Avalon-MM slave
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Converter
  output logic conv_start_o,
  output logic [$clog2(NCH)-1:0] conv_ch_o,
  input wire logic conv_done_i,
  input wire logic conv_err_i,
  input wire logic [aiq_pkg::AIQ_DW-1:0] conv_data_i,
  // External control inputs and the busy output
  input wire logic ext_clk_i,
  input wire logic ext_trig_i,
  output logic busy_o
);
  import aiq_pkg::*;
  // All checks below run on the bus clock and sleep through reset
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  localparam int CW = $clog2(NCH);
  localparam int AW = $clog2(DEPTH);

  // Channel fields are three bits wide and the store must be a power of two
  if (NCH < 2 || NCH > 8 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
    $error("aiq_sequencer: unsupported NCH or DEPTH");
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  logic [31:0] cfg_q, chen_q, period_q, slvl_q, plvl_q, stopcnt_q, thr_q;
  logic [AIQ_NEV-1:0] evt_q;
  logic wait_q;
  logic [31:0] rdata_q;
  aiq_state_type st_q, st_d;
  aiq_phase_type ph_q;
  logic [CW-1:0] ch_q;
  logic issued_q, conv_start_q, store_q, stop_pend_q, prev_ok_q;
  logic [CW-1:0] conv_ch_q;
  logic [15:0] sbuf_q [NCH];
  logic [15:0] prev_s_q, prev_p_q;
  logic [31:0] tmr_q, run_inst_q;
  logic clk_prev_q, trig_prev_q, busy_q;
  logic [15:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q, rptr_q;
  logic [AW:0] wcnt_q;
  logic cr_q, ovf_q, clke_q, cnve_q;

  // Bus decode; a request is taken on the edge where waitrequest is low
  wire req = avs_read_i | avs_write_i;
  wire acc = req & ~wait_q;
  wire wr_acc = avs_write_i & acc;
  wire rd_acc = avs_read_i & acc;
  wire [31:0] wdat = avs_writedata_i;
  wire [3:0] be = avs_byteenable_i;
  wire wr_ctrl = wr_acc & (avs_address_i == AIQ_OFS_CTRL) & be[0];
  wire wr_evt = wr_acc & (avs_address_i == AIQ_OFS_EVENT);
  wire rd_data = rd_acc & (avs_address_i == AIQ_OFS_DATA);
  wire [5:0] wa = wr_acc ? avs_address_i : 6'h3F; // 0x3F maps to nothing
  wire cmd_start = wr_ctrl & wdat[AIQ_CTRL_START];
  wire cmd_abort = wr_ctrl & wdat[AIQ_CTRL_ABORT];
  wire cmd_memrst = wr_ctrl & wdat[AIQ_CTRL_MEMRST];
  wire cmd_stsrst = wr_ctrl & wdat[AIQ_CTRL_STSRST];

  // Configuration fields
  wire cfg_ring = cfg_q[AIQ_CFG_RING];
  wire cfg_ext = cfg_q[AIQ_CFG_EXTCLK];
  wire [1:0] start_src = cfg_q[AIQ_CFG_SRC_LSB +: 2];
  wire [1:0] stop_src = cfg_q[AIQ_CFG_STP_LSB +: 2];
  wire [1:0] sdir = cfg_q[AIQ_CFG_SDIR_LSB +: 2];
  wire [1:0] pdir = cfg_q[AIQ_CFG_PDIR_LSB +: 2];
  wire [CW-1:0] sch = cfg_q[AIQ_CFG_SCH_LSB +: CW];
  wire [CW-1:0] pch = cfg_q[AIQ_CFG_PCH_LSB +: CW];
  wire [NCH-1:0] chen = chen_q[NCH-1:0];

  // Edge detection on the external pins, taken as synchronous
  wire ext_rise = ext_clk_i & ~clk_prev_q;
  wire trig_r = ext_trig_i & ~trig_prev_q;
  wire trig_f = ~ext_trig_i & trig_prev_q;
  wire s_edge = cfg_q[AIQ_CFG_SEDGE] ? trig_f : trig_r;
  wire p_edge = cfg_q[AIQ_CFG_PEDGE] ? trig_f : trig_r;

  // Pacing: sampling runs while storing, or while hunting for a crossing
  wire ticking = (st_q == AIQ_RUN) |
                 (st_q == AIQ_ARM && start_src == AIQ_SRC_CMP);
  wire tick = ticking & (cfg_ext ? ext_rise : (tmr_q == 32'h0));
  wire [31:0] per_m1 = (period_q == 32'h0) ? 32'h0 : period_q - 32'h1;

  // Scan progress
  wire last_ch = (ch_q == CW'(NCH - 1));
  wire ch_en = chen[ch_q];
  wire conv_ok = (ph_q == AIQ_PH_CONV) & issued_q & conv_done_i;

  // Crossing decisions, made once the whole instant has been converted
  wire eval = (ph_q == AIQ_PH_EVAL);
  wire start_hit = eval & (st_q == AIQ_ARM) & prev_ok_q &
                   aiq_cross(prev_s_q, sbuf_q[sch], slvl_q[15:0], sdir);
  wire stop_cmp = eval & (st_q == AIQ_RUN) & prev_ok_q &
                  (stop_src == AIQ_STP_CMP) &
                  aiq_cross(prev_p_q, sbuf_q[pch], plvl_q[15:0], pdir);
  wire store_now = (st_q == AIQ_RUN) | start_hit;
  wire cnt_met = store_now & (run_inst_q + 32'h1 >= stopcnt_q);
  wire stop_cnt = eval & (stop_src == AIQ_STP_COUNT) & cnt_met;
  wire commit_end = (ph_q == AIQ_PH_COMMIT) & last_ch;

  // Store write and overflow
  wire full = (wcnt_q == (AW + 1)'(DEPTH));
  wire empty = (wcnt_q == '0);
  wire wr_word = (ph_q == AIQ_PH_COMMIT) & ch_en & store_q;
  wire wr_ovf = wr_word & full;
  wire wr_ok = wr_word & (~full | cfg_ring);
  wire pop = rd_data & ~empty;

  // Errors and stops
  wire clk_err = tick & (ph_q != AIQ_PH_IDLE);
  wire cnv_err = conv_ok & conv_err_i;
  wire err_any = clk_err | cnv_err | (wr_ovf & ~cfg_ring);
  wire ext_stop = (st_q == AIQ_RUN) & (stop_src == AIQ_STP_EXT) &
                  (run_inst_q >= stopcnt_q) & p_edge;
  wire hard_stop = (st_q != AIQ_IDLE) &
                   (cmd_abort | ext_stop | err_any);
  wire start_met = start_hit |
                   ((st_q == AIQ_ARM) & (start_src == AIQ_SRC_EXT) & s_edge);

  // Threshold in stored words: instants times enabled channels
  wire [31:0] nen = 32'($countones(chen));
  wire [31:0] thrw = thr_q * nen;
  wire reach = (thr_q != 32'h0) & ({{(31 - AW){1'b0}}, wcnt_q} >= thrw);
  wire cr_d = cfg_ring ? (cr_q | reach) : reach;

  // Sequencer next state
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      AIQ_IDLE: begin
        if (cmd_start) begin
          st_d = (start_src == AIQ_SRC_SW) ? AIQ_RUN : AIQ_ARM;
        end
      end
      AIQ_ARM: begin
        if (start_met) begin
          st_d = AIQ_RUN;
        end
      end
      AIQ_RUN: begin
        if (commit_end && stop_pend_q) begin
          st_d = AIQ_IDLE;
        end
      end
    endcase
    if (hard_stop) begin
      st_d = AIQ_IDLE;
    end
  end

  wire stop_evt = (st_q != AIQ_IDLE) & (st_d == AIQ_IDLE);
  wire [AIQ_NEV-1:0] ev_set = {cnv_err, clk_err & (st_q != AIQ_IDLE),
      wr_ovf, cr_d & ~cr_q, stop_evt,
      start_met & (start_src != AIQ_SRC_SW)};
  wire [15:0] head = mem_q[rptr_q];

  // Read data selection
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (avs_address_i)
      AIQ_OFS_CFG: rd_mux = cfg_q;
      AIQ_OFS_CHEN: rd_mux = chen_q;
      AIQ_OFS_PERIOD: rd_mux = period_q;
      AIQ_OFS_SLVL: rd_mux = slvl_q;
      AIQ_OFS_PLVL: rd_mux = plvl_q;
      AIQ_OFS_STOPCNT: rd_mux = stopcnt_q;
      AIQ_OFS_THR: rd_mux = thr_q;
      AIQ_OFS_STATUS: rd_mux = {26'h0, cnve_q, clke_q, ovf_q, cr_q,
                                st_q == AIQ_ARM, st_q != AIQ_IDLE};
      AIQ_OFS_EVENT: rd_mux = {26'h0, evt_q};
      AIQ_OFS_COUNT: rd_mux = {{(31 - AW){1'b0}}, wcnt_q};
      AIQ_OFS_DATA: rd_mux = {16'h0, head};
      default: rd_mux = 32'h0;
    endcase
  end

  // Bus handshake: one wait cycle, then the answer
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0;
    end else begin
      wait_q <= ~(req & wait_q);
      if (req && wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Software registers; events are write-one-to-clear, set wins
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_q <= AIQ_CFG_RST;
      chen_q <= AIQ_CHEN_RST;
      period_q <= AIQ_PERIOD_RST;
      slvl_q <= AIQ_LVL_RST;
      plvl_q <= AIQ_LVL_RST;
      stopcnt_q <= AIQ_STOPCNT_RST;
      thr_q <= AIQ_THR_RST;
      evt_q <= '0;
    end else begin
      if (wa == AIQ_OFS_CFG) cfg_q <= merge(cfg_q, wdat, be);
      if (wa == AIQ_OFS_CHEN) chen_q <= merge(chen_q, wdat, be);
      if (wa == AIQ_OFS_PERIOD) period_q <= merge(period_q, wdat, be);
      if (wa == AIQ_OFS_SLVL) slvl_q <= merge(slvl_q, wdat, be);
      if (wa == AIQ_OFS_PLVL) plvl_q <= merge(plvl_q, wdat, be);
      if (wa == AIQ_OFS_STOPCNT) stopcnt_q <= merge(stopcnt_q, wdat, be);
      if (wa == AIQ_OFS_THR) thr_q <= merge(thr_q, wdat, be);
      evt_q <= (evt_q & ~((wr_evt & be[0]) ? wdat[AIQ_NEV-1:0] : '0)) | ev_set;
    end
  end

  // Sequencer, pacing timer and trigger edge history
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= AIQ_IDLE;
      tmr_q <= 32'h0;
      clk_prev_q <= 1'b0;
      trig_prev_q <= 1'b0;
      stop_pend_q <= 1'b0;
      run_inst_q <= 32'h0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      busy_q <= (st_d != AIQ_IDLE); // tracks st_q, but from a flip-flop
      clk_prev_q <= ext_clk_i;
      trig_prev_q <= ext_trig_i;
      tmr_q <= !ticking ? 32'h0 : (tmr_q == 32'h0 ? per_m1 : tmr_q - 32'h1);
      if (cmd_start && st_q == AIQ_IDLE) begin
        stop_pend_q <= 1'b0;
        run_inst_q <= 32'h0;
      end else if (eval) begin
        stop_pend_q <= stop_cnt | stop_cmp;
        if (store_now) run_inst_q <= run_inst_q + 32'h1;
      end
    end
  end

  // Channel scan: convert each enabled channel, judge, then store
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ph_q <= AIQ_PH_IDLE;
      ch_q <= '0;
      issued_q <= 1'b0;
      conv_start_q <= 1'b0;
      conv_ch_q <= '0;
      store_q <= 1'b0;
      prev_ok_q <= 1'b0;
      prev_s_q <= 16'h0;
      prev_p_q <= 16'h0;
    end else begin
      conv_start_q <= 1'b0;
      if (cmd_start && st_q == AIQ_IDLE) prev_ok_q <= 1'b0;
      if (hard_stop || st_q == AIQ_IDLE) begin
        ph_q <= AIQ_PH_IDLE; // a late converter answer is dropped
        issued_q <= 1'b0;
      end else begin
        unique case (ph_q)
          AIQ_PH_IDLE: begin
            if (tick) begin
              ph_q <= AIQ_PH_CONV;
              ch_q <= '0;
            end
          end
          AIQ_PH_CONV: begin
            if (!ch_en || conv_ok) begin
              issued_q <= 1'b0;
              ch_q <= last_ch ? '0 : ch_q + CW'(1);
              if (last_ch) ph_q <= AIQ_PH_EVAL;
            end else if (!issued_q) begin
              conv_start_q <= 1'b1;
              conv_ch_q <= ch_q;
              issued_q <= 1'b1;
            end
          end
          AIQ_PH_EVAL: begin
            store_q <= store_now;
            prev_ok_q <= 1'b1;
            prev_s_q <= sbuf_q[sch];
            prev_p_q <= sbuf_q[pch];
            ph_q <= AIQ_PH_COMMIT;
          end
          AIQ_PH_COMMIT: begin
            ch_q <= last_ch ? '0 : ch_q + CW'(1);
            if (last_ch) ph_q <= AIQ_PH_IDLE;
          end
        endcase
      end
    end
  end

  // Per-channel capture of the current instant
  always_ff @(posedge mclk_i) begin
    if (conv_ok) sbuf_q[ch_q] <= conv_data_i;
  end

  // Sample store contents
  always_ff @(posedge mclk_i) begin
    if (wr_ok) mem_q[wptr_q] <= sbuf_q[ch_q];
  end

  // Store pointers and memory related status
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wptr_q <= '0;
      rptr_q <= '0;
      wcnt_q <= '0;
      cr_q <= 1'b0;
      ovf_q <= 1'b0;
    end else if (cmd_memrst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      wcnt_q <= '0;
      cr_q <= 1'b0;
      ovf_q <= 1'b0;
    end else begin
      cr_q <= cr_d;
      if (wr_ovf) ovf_q <= 1'b1;
      if (wr_ok) wptr_q <= wptr_q + AW'(1);
      if (wr_ok && full) begin
        rptr_q <= wptr_q + AW'(1);
      end else if (pop) begin
        rptr_q <= rptr_q + AW'(1);
      end
      if (cfg_ring) begin
        if (wr_ok && !full) wcnt_q <= wcnt_q + (AW + 1)'(1);
      end else if (wr_ok && !pop) begin
        wcnt_q <= wcnt_q + (AW + 1)'(1);
      end else if (pop && !wr_ok) begin
        wcnt_q <= wcnt_q - (AW + 1)'(1);
      end
    end
  end

  // Error status, held until a status reset; a new error wins
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clke_q <= 1'b0;
      cnve_q <= 1'b0;
    end else begin
      clke_q <= (clke_q & ~cmd_stsrst) | (clk_err & (st_q != AIQ_IDLE));
      cnve_q <= (cnve_q & ~cmd_stsrst) | cnv_err;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign conv_start_o = conv_start_q;
  assign conv_ch_o = conv_ch_q;
  assign busy_o = busy_q;

  // Checks
  bus_wait_one_a: assert property (
    (req && wait_q) |=> !wait_q) else $error("bus answer late");
  scan_from_zero_a: assert property (
    (ph_q == AIQ_PH_IDLE && tick && st_d != AIQ_IDLE) |=> ch_q == '0)
    else $error("scan not from channel 0");
  fifo_head_a: assert property (
    (avs_read_i && wait_q && avs_address_i == AIQ_OFS_DATA) |=>
    avs_readdata_o[15:0] == $past(head)) else $error("data not oldest");
  fifo_ovf_stop_a: assert property (
    (wr_ovf && !cfg_ring) |=> st_q == AIQ_IDLE ##0 ovf_q)
    else $error("fifo overflow did not stop");
  error_halt_a: assert property (
    (st_q != AIQ_IDLE && (clk_err || cnv_err)) |=>
    st_q == AIQ_IDLE && ph_q == AIQ_PH_IDLE) else $error("error not halting");
  sw_no_start_a: assert property (
    (st_q == AIQ_IDLE && cmd_start && start_src == AIQ_SRC_SW) |=>
    st_q == AIQ_RUN && !$rose(evt_q[AIQ_EV_START]))
    else $error("software start misbehaved");
  stop_event_a: assert property (
    $fell(busy_o) |-> evt_q[AIQ_EV_STOP]) else $error("no stopped event");
  evt_set_wins_a: assert property (
    (|ev_set) |=> (evt_q & $past(ev_set)) == $past(ev_set))
    else $error("event lost");
  count_stop_a: assert property (
    (stop_cnt && !hard_stop) |=> stop_pend_q ##[1:16] st_q == AIQ_IDLE)
    else $error("count stop missed");
  abort_stop_a: assert property (
    (cmd_abort && st_q != AIQ_IDLE) |=> st_q == AIQ_IDLE)
    else $error("abort ignored");
endmodule // aiq_sequencer

// *** aiq_conv_model.sv ***
`timescale 1ns/1ns
// Behavioural converter: answers each start after lat_i cycles
module aiq_conv_model (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Converter side of the sequencer
  input wire logic start_i,
  input wire logic [2:0] ch_i,
  output logic done_o,
  output logic err_o,
  output logic [15:0] data_o,
  // Bench controls
  input wire logic [7:0] lat_i,
  input wire logic fault_i,
  input wire logic clr_i
);
  logic [7:0] cnt_q;
  logic [2:0] ch_q;
  logic [3:0] k_q [8];
  // Code is channel in [14:12], per-channel instant in [11:8]; the data
  // toggles outside the done pulse so a stale word never looks fresh
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= 8'h00;
      ch_q <= 3'h0;
      done_o <= 1'b0;
      err_o <= 1'b0;
      data_o <= 16'h0000;
      k_q <= '{default: 4'h0};
    end else begin
      done_o <= 1'b0;
      err_o <= 1'b0;
      data_o <= ~data_o;
      if (clr_i) k_q <= '{default: 4'h0};
      if (start_i) begin
        cnt_q <= lat_i;
        ch_q <= ch_i;
      end else if (cnt_q == 8'h01) begin
        cnt_q <= 8'h00;
        done_o <= 1'b1;
        err_o <= fault_i;
        data_o <= {1'b0, ch_q, k_q[ch_q], 8'h00};
        k_q[ch_q] <= k_q[ch_q] + 4'h1;
      end else if (cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule // aiq_conv_model

// *** aiq_sequencer_tb_top.sv ***
`timescale 1ns/1ns
module aiq_sequencer_tb_top;
  import aiq_pkg::*;
  localparam int DEPTH = 8;
  // Bench-driven inputs
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic ext_clk = 1'b0;
  logic ext_trig = 1'b1;
  logic [7:0] lat = 8'h03;
  logic fault = 1'b0;
  logic clr = 1'b0;
  // Design outputs and converter answers
  logic [31:0] avs_readdata;
  logic avs_waitrequest, conv_start, conv_done, conv_err, busy;
  logic [2:0] conv_ch;
  logic [15:0] conv_data;
  logic [31:0] q;
  int fails = 0;
  int n_checks = 0;
  int n_conv = 0;

  aiq_sequencer #(.NCH(AIQ_NCH), .DEPTH(DEPTH)) aiq_sequencer_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .avs_address_i(avs_address),
    .avs_read_i(avs_read), .avs_write_i(avs_write),
    .avs_writedata_i(avs_writedata), .avs_byteenable_i(4'hF),
    .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
    .conv_start_o(conv_start), .conv_ch_o(conv_ch),
    .conv_done_i(conv_done), .conv_err_i(conv_err),
    .conv_data_i(conv_data), .ext_clk_i(ext_clk), .ext_trig_i(ext_trig),
    .busy_o(busy));
  aiq_conv_model aiq_conv_model_inst (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .start_i(conv_start),
    .ch_i(conv_ch), .done_o(conv_done), .err_o(conv_err),
    .data_o(conv_data), .lat_i(lat), .fault_i(fault), .clr_i(clr));

  // Free-running 100 MHz clock
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  // Conversions answered since the last model clear
  always @(posedge mclk_i) begin
    if (clr) n_conv <= 0;
    else if (conv_done === 1'b1) n_conv <= n_conv + 1;
  end

  task automatic chk(input logic [31:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // One bus cycle; holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0, "bus timeout");
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge mclk_i);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(q, exp, $sformatf("read at %h", a));
  endtask
  // Bounded wait for the acquisition to end
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge mclk_i);
      n++;
    end
    chk({31'h0, busy}, 32'h0, "still busy");
  endtask
  // Clear store, status and events, configure, then start
  task automatic launch(input logic [31:0] cfg, chen, per, cnt, thr);
    clr <= 1'b1;
    bus(1'b1, AIQ_OFS_CTRL, 32'h0000000C);
    bus(1'b1, AIQ_OFS_EVENT, 32'h0000003F);
    bus(1'b1, AIQ_OFS_CFG, cfg);
    bus(1'b1, AIQ_OFS_CHEN, chen);
    bus(1'b1, AIQ_OFS_PERIOD, per);
    bus(1'b1, AIQ_OFS_STOPCNT, cnt);
    bus(1'b1, AIQ_OFS_THR, thr);
    clr <= 1'b0;
    bus(1'b1, AIQ_OFS_CTRL, 32'h00000001);
  endtask
  // Channel 0 only: n words holding instants k0 onwards
  task automatic drain(input int n, input int k0);
    rdchk(AIQ_OFS_COUNT, 32'(n));
    for (int i = 0; i < n; i++) begin
      rdchk(AIQ_OFS_DATA, 32'((k0 + i) * 'h100));
    end
  endtask
  task automatic ext_pulse;
    ext_clk <= 1'b1;
    repeat (2) @(posedge mclk_i);
    ext_clk <= 1'b0;
    repeat (40) @(posedge mclk_i);
  endtask
  task automatic note(input string s);
    $display("test %s finished", s);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog: the tests need well under a third of this span
  initial begin
    repeat (60000) @(posedge mclk_i);
    fails++;
    tally_and_finish;
  end

  initial begin
    repeat (20) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    @(posedge mclk_i);
    rdchk(AIQ_OFS_CFG, AIQ_CFG_RST);
    rdchk(AIQ_OFS_CHEN, AIQ_CHEN_RST);
    rdchk(AIQ_OFS_PERIOD, AIQ_PERIOD_RST);
    rdchk(AIQ_OFS_STOPCNT, AIQ_STOPCNT_RST);
    bus(1'b1, 6'h30, 32'hFFFFFFFF);
    rdchk(6'h30, 32'h00000000);
    bus(1'b1, AIQ_OFS_SLVL, 32'h00000250);
    bus(1'b1, AIQ_OFS_PLVL, 32'h00000250);
    note("reset");
    // Channels 0 and 2, threshold of two instants
    launch(32'h0, 32'h5, 32'h28, 32'h3, 32'h2);
    wait_idle;
    rdchk(AIQ_OFS_EVENT, 32'h6);
    rdchk(AIQ_OFS_STATUS, 32'h4);
    rdchk(AIQ_OFS_COUNT, 32'h6);
    for (int i = 0; i < 6; i++) begin
      rdchk(AIQ_OFS_DATA, 32'((i % 2) * 'h2000 + (i / 2) * 'h100));
      if (i == 2) rdchk(AIQ_OFS_STATUS, 32'h0);
    end
    note("scan");
    // Rising crossing of 0x250 on channel 0 starts storage
    launch(32'h44, 32'h1, 32'h28, 32'h2, 32'h0);
    rdchk(AIQ_OFS_STATUS, 32'h3);
    wait_idle;
    rdchk(AIQ_OFS_EVENT, 32'h3);
    drain(2, 3);
    // Crossing in either direction ends storage
    launch(32'h310, 32'h1, 32'h28, 32'h64, 32'h0);
    wait_idle;
    rdchk(AIQ_OFS_EVENT, 32'h2);
    drain(4, 0);
    note("compare");
    // External clock, falling trigger start, abort stop
    launch(32'h43A, 32'h1, 32'h28, 32'h64, 32'h0);
    rdchk(AIQ_OFS_STATUS, 32'h3);
    ext_trig <= 1'b0;
    repeat (20) @(posedge mclk_i);
    repeat (3) ext_pulse;
    bus(1'b1, AIQ_OFS_CTRL, 32'h00000002);
    wait_idle;
    rdchk(AIQ_OFS_EVENT, 32'h3);
    drain(3, 0);
    // Trigger stop is ignored until two instants are stored
    launch(32'h20, 32'h1, 32'h28, 32'h2, 32'h0);
    ext_trig <= 1'b1;
    repeat (200) @(posedge mclk_i);
    chk({31'h0, busy}, 32'h1, "stopped early");
    ext_trig <= 1'b0;
    repeat (2) @(posedge mclk_i);
    ext_trig <= 1'b1;
    wait_idle;
    rdchk(AIQ_OFS_EVENT, 32'h2);
    note("external");
    // Ten instants into eight words: FIFO stops, ring overwrites
    for (int r = 0; r < 2; r++) begin
      launch(32'(r), 32'h1, 32'h28, 32'hA, 32'h0);
      wait_idle;
      chk(32'(n_conv), r ? 32'hA : 32'h9, "conversions");
      rdchk(AIQ_OFS_EVENT, 32'hA);
      rdchk(AIQ_OFS_STATUS, 32'h8);
      drain(DEPTH, 2 * r);
    end
    note("overflow");
    // Converter fault, then a period shorter than the scan
    for (int e = 0; e < 2; e++) begin
      fault <= (e == 0);
      lat <= e ? 8'h14 : 8'h03;
      launch(32'h0, 32'h1, e ? 32'h3 : 32'h28, 32'h3, 32'h0);
      wait_idle;
      rdchk(AIQ_OFS_EVENT, e ? 32'h12 : 32'h22);
      bus(1'b1, AIQ_OFS_CTRL, 32'h00000008);
      rdchk(AIQ_OFS_STATUS, 32'h0);
    end
    fault <= 1'b0;
    note("errors");
    tally_and_finish;
  end
endmodule // aiq_sequencer_tb_top
